// file: rtl/insn_decode_pkg.sv
// Constants, types and encodings for the skip, exclusive-OR and extended-instruction decoder
// Function
// - Zero test discards prefetched word, two cycles
// - Skipped two-word instruction costs three cycles
// - Access bit low: access bank; high: bank select
// - Access bank, extension on, f<=95: indexed offset
// - Literal XOR lands in accumulator, one cycle
// - Register XOR decoded from 000110da, one cycle
// - Destination bit picks accumulator or register
// - Register XOR sets N,Z; test touches none
// - Extension inactive unless its enable is set
// - Extension adds exactly eight instructions
// - Pointer add one cycle; select 11 returns
// - Pointer subtract one cycle; select 11 returns
// - Pointer-two variants return after the update
// - Accumulator call: two cycles, no flags
// - Two-word indexed moves, second word 1111
// - Push literal at pointer two, then decrement
// - Accumulator call sends the accumulator out as call target low byte
// - Return variant spends second cycle idle
package insn_decode_pkg;
	// ****************************************
	// Instruction cycle phases
	// ****************************************
	localparam logic [1:0] PH_DECODE = 2'h0;
	localparam logic [1:0] PH_READ = 2'h1;
	localparam logic [1:0] PH_PROC = 2'h2;
	localparam logic [1:0] PH_WRITE = 2'h3;
	localparam int CLK_PERIOD_NS = 50;
	localparam int PHASES_PER_CYCLE = 4;
	localparam int INSN_CYCLE_NS = CLK_PERIOD_NS * PHASES_PER_CYCLE;
	// ****************************************
	// Opcode masks and values
	// ****************************************
	localparam logic [15:0] M_TST = 16'hfe00;
	localparam logic [15:0] V_TST = 16'h6600;
	localparam logic [15:0] M_XOR_LITERAL_INTO_ACC = 16'hff00;
	localparam logic [15:0] V_XOR_LITERAL_INTO_ACC = 16'h0a00;
	localparam logic [15:0] M_XOR_ACC_WITH_REG = 16'hfc00;
	localparam logic [15:0] V_XOR_ACC_WITH_REG = 16'h1800;
	localparam logic [15:0] M_BYTE8 = 16'hff00;
	localparam logic [15:0] V_ADDPTR = 16'he800;
	localparam logic [15:0] V_SUBPTR = 16'he900;
	localparam logic [15:0] V_PUSH_LITERAL = 16'hea00;
	localparam logic [15:0] V_MOVS = 16'heb00;
	localparam logic [15:0] M_FULL = 16'hffff;
	localparam logic [15:0] V_CALL_VIA_ACCUMULATOR = 16'h0014;
	localparam logic [15:0] M_NIB = 16'hf000;
	localparam logic [15:0] V_SECOND = 16'hf000;
	localparam logic [15:0] M_CALL = 16'hfe00;
	localparam logic [15:0] V_CALL = 16'hec00;
	localparam logic [15:0] V_GOTO = 16'hef00;
	localparam logic [15:0] M_LFSR = 16'hffc0;
	localparam logic [15:0] V_LFSR = 16'hee00;
	localparam logic [15:0] V_MOVFF = 16'hc000;
	localparam int STD_INSN_COUNT = 75;
	localparam int EXT_INSN_COUNT = 8;
	// ****************************************
	// Opcode fields and addressing
	// ****************************************
	localparam int BIT_A = 8;
	localparam int BIT_D = 9;
	localparam int BIT_MOVE_INDEXED_TO_INDEXED = 7;
	localparam logic [1:0] SEL_PTR2_RET = 2'h3;
	localparam logic [7:0] ILO_LIMIT = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] SFR_PAGE = 4'hf;
	// ****************************************
	// Register map (byte offsets) and fields
	// ****************************************
	localparam int WB_AW = 5;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_ACC = 5'h04;
	localparam logic [4:0] REG_BANK = 5'h08;
	localparam logic [4:0] REG_PTR0 = 5'h0c;
	localparam logic [4:0] REG_PTR1 = 5'h10;
	localparam logic [4:0] REG_PTR2 = 5'h14;
	localparam logic [4:0] REG_STATUS = 5'h18;
	localparam logic [4:0] REG_STATE = 5'h1c;
	localparam int CTRL_EXT_BIT = 0;
	localparam int STAT_Z_BIT = 2;
	localparam int STAT_N_BIT = 4;
	localparam logic RST_EXT = 1'b0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [11:0] RST_PTR = 12'h000;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ST_EXEC = 3'h0,
		ST_SKIP = 3'h1,
		ST_SKIP2 = 3'h3,
		ST_DEAD = 3'h2,
		ST_MOV2 = 3'h6
	} state_t;
	typedef struct packed {
		logic [11:0] addr;
		logic we;
		logic [7:0] wdat;
	} mem_req_t;
endpackage

// file: rtl/ext_insn_decoder.sv
// Decoder and executor for skip, exclusive-OR and extended pointer instructions
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ext_insn_decoder import insn_decode_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [WB_AW-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Instruction fetch
	input wire logic [15:0] i_insn,
	output logic [1:0] o_phase,
	output logic o_flush,
	// Data memory
	input wire logic [7:0] i_mem_rdat,
	output mem_req_t o_mem,
	// Program flow
	output logic o_call,
	output logic o_ret,
	output logic [7:0] o_pcl
);
	// ****************************************
	// State
	// ****************************************
	state_t state_q; // Cycle sequencer
	logic [1:0] phase_q; // Current phase
	logic [15:0] ir_q; // Word being executed
	logic flush_two_q; // Word of this cycle is a two-word first word
	logic mv_idx_q; // Move destination is indexed
	logic [7:0] rd_q; // Operand read in phase two
	logic ext_q; // Extension enable
	logic [7:0] acc_q; // Accumulator
	logic [3:0] bank_q; // Bank select
	logic [11:0] ptr_q [3]; // File select pointers
	logic n_q; // Negative flag
	logic z_q; // Zero flag
	logic flush_q; // Flushed-cycle flag
	mem_req_t mem_q; // Memory request
	logic call_q; // Call pulse
	logic ret_q; // Return pulse
	logic [7:0] pcl_q; // Call target low byte
	logic ack_q; // Bus acknowledge
	logic [31:0] wb_dat_q; // Bus read data
	// ****************************************
	// Decode helpers
	// ****************************************
	// Masked opcode match
	function automatic logic hit(input logic [15:0] w, input logic [15:0] m, input logic [15:0] v);
		return (w & m) == v;
	endfunction
	// First word of an instruction that owns a second word
	function automatic logic is_two_word(input logic [15:0] w, input logic ext);
		return hit(w, M_CALL, V_CALL) || hit(w, M_BYTE8, V_GOTO) || hit(w, M_LFSR, V_LFSR)
			|| hit(w, M_NIB, V_MOVFF) || (ext && hit(w, M_BYTE8, V_MOVS));
	endfunction
	// Byte-oriented operand address
	function automatic logic [11:0] resolve(input logic [15:0] w, input logic ext, input logic [3:0] bank,
		input logic [11:0] p2);
		logic [7:0] f;
		f = w[7:0];
		if (w[BIT_A])
			return {bank, f};
		else if (ext && f <= ILO_LIMIT)
			return 12'(p2 + {4'h0, f});
		else if (f >= ACCESS_SPLIT)
			return {SFR_PAGE, f};
		else
			return {4'h0, f};
	endfunction
	// Byte-lane merge for bus writes
	function automatic logic [11:0] merge12(input logic [11:0] old, input logic [31:0] d, input logic [3:0] s);
		return {s[1] ? d[11:8] : old[11:8], s[0] ? d[7:0] : old[7:0]};
	endfunction
	// ****************************************
	// Instruction decode
	// ****************************************
	wire active = state_q == ST_EXEC;
	wire mv2 = state_q == ST_MOV2;
	wire dec_tst = active && hit(ir_q, M_TST, V_TST);
	wire dec_xor_literal_into_acc = active && hit(ir_q, M_XOR_LITERAL_INTO_ACC, V_XOR_LITERAL_INTO_ACC);
	wire dec_xor_acc_with_reg = active && hit(ir_q, M_XOR_ACC_WITH_REG, V_XOR_ACC_WITH_REG);
	// Eight extended kinds, all gated by the enable
	wire dec_add = active && ext_q && hit(ir_q, M_BYTE8, V_ADDPTR);
	wire dec_sub = active && ext_q && hit(ir_q, M_BYTE8, V_SUBPTR);
	wire dec_push = active && ext_q && hit(ir_q, M_BYTE8, V_PUSH_LITERAL);
	wire dec_movs = active && ext_q && hit(ir_q, M_BYTE8, V_MOVS);
	wire dec_call_via_accumulator = active && ext_q && hit(ir_q, M_FULL, V_CALL_VIA_ACCUMULATOR);
	wire mv2_ok = mv2 && hit(ir_q, M_NIB, V_SECOND);
	wire is_ulnk = ir_q[7:6] == SEL_PTR2_RET;
	wire [1:0] ptr_idx = is_ulnk ? 2'h2 : ir_q[7:6];
	wire [11:0] lit6 = {6'h00, ir_q[5:0]};
	wire [11:0] ptr_sel = ptr_q[ptr_idx];
	wire [11:0] ptr_new = dec_add ? 12'(ptr_sel + lit6) : 12'(ptr_sel - lit6);
	wire [11:0] idx_addr = 12'(ptr_q[2] + {5'h00, ir_q[6:0]});
	wire [11:0] byte_addr = resolve(ir_q, ext_q, bank_q, ptr_q[2]);
	wire [11:0] addr_d = dec_push ? ptr_q[2] : dec_movs ? idx_addr
		: mv2 ? (mv_idx_q ? idx_addr : ir_q[11:0]) : byte_addr;
	wire [7:0] xor_res = acc_q ^ (dec_xor_literal_into_acc ? ir_q[7:0] : rd_q);
	// Next cycle kind, decided in the write phase
	wire skip_now = dec_tst && rd_q == 8'h00;
	wire ret_now = (dec_add || dec_sub) && is_ulnk;
	state_t state_d;
	assign state_d = skip_now ? ST_SKIP
		: dec_movs ? ST_MOV2
		: (ret_now || dec_call_via_accumulator) ? ST_DEAD
		: (state_q == ST_SKIP && flush_two_q) ? ST_SKIP2
		: ST_EXEC;
	// ****************************************
	// Bus decode
	// ****************************************
	wire bus_hit = i_wb_cyc && i_wb_stb;
	wire wr_now = bus_hit && i_wb_we && ack_q;
	wire [31:0] rd_mux = i_wb_adr == REG_CTRL ? {31'h0, ext_q}
		: i_wb_adr == REG_ACC ? {24'h0, acc_q}
		: i_wb_adr == REG_BANK ? {28'h0, bank_q}
		: i_wb_adr == REG_PTR0 ? {20'h0, ptr_q[0]}
		: i_wb_adr == REG_PTR1 ? {20'h0, ptr_q[1]}
		: i_wb_adr == REG_PTR2 ? {20'h0, ptr_q[2]}
		: i_wb_adr == REG_STATUS ? {27'h0, n_q, 1'b0, z_q, 2'h0}
		: i_wb_adr == REG_STATE ? {27'h0, phase_q, state_q}
		: 32'h0;
	// ****************************************
	// Phase counter
	// ****************************************
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			phase_q <= PH_DECODE;
		else
			phase_q <= 2'(phase_q + 2'h1);
	end
	// ****************************************
	// Bus slave: ack one cycle after request
	// ****************************************
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			ack_q <= 1'b0;
			wb_dat_q <= 32'h0;
		end
		else
		begin
			ack_q <= bus_hit && !ack_q;
			wb_dat_q <= rd_mux;
		end
	end
	// ****************************************
	// Execute, one phase per clock
	// ****************************************
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state_q <= ST_EXEC;
			ir_q <= 16'h0000;
			flush_two_q <= 1'b0;
			mv_idx_q <= 1'b0;
			rd_q <= RST_BYTE;
			ext_q <= RST_EXT;
			acc_q <= RST_BYTE;
			bank_q <= 4'h0;
			ptr_q <= '{RST_PTR, RST_PTR, RST_PTR};
			n_q <= 1'b0;
			z_q <= 1'b0;
			flush_q <= 1'b0;
			mem_q <= '0;
			call_q <= 1'b0;
			ret_q <= 1'b0;
			pcl_q <= RST_BYTE;
		end
		else
		begin
			case (phase_q)
				// Latch the word and note whether a skip must drop two
				PH_DECODE:
				begin
					ir_q <= i_insn;
					flush_two_q <= is_two_word(i_insn, ext_q);
					mem_q.we <= 1'b0;
					call_q <= 1'b0;
					ret_q <= 1'b0;
				end
				// Present the operand address
				PH_READ:
				begin
					mem_q.addr <= addr_d;
				end
				// Capture the operand; a move's second cycle keeps its source byte
				PH_PROC:
				begin
					if (!mv2)
						rd_q <= i_mem_rdat;
				end
				// Commit results; flushed cycles commit nothing
				default:
				begin
					state_q <= state_d;
					flush_q <= state_d != ST_EXEC && state_d != ST_MOV2;
					if (dec_movs)
						mv_idx_q <= ir_q[BIT_MOVE_INDEXED_TO_INDEXED];
					if (dec_xor_literal_into_acc || (dec_xor_acc_with_reg && !ir_q[BIT_D]))
						acc_q <= xor_res;
					if (dec_xor_acc_with_reg)
					begin
						n_q <= xor_res[7];
						z_q <= xor_res == 8'h00;
					end
					if ((dec_xor_acc_with_reg && ir_q[BIT_D]) || dec_push || mv2_ok)
					begin
						mem_q.we <= 1'b1;
						mem_q.wdat <= dec_push ? ir_q[7:0] : mv2_ok ? rd_q : xor_res;
					end
					if (dec_add || dec_sub)
						ptr_q[ptr_idx] <= ptr_new;
					if (dec_push)
						ptr_q[2] <= 12'(ptr_q[2] - 12'h001);
					ret_q <= ret_now;
					call_q <= dec_call_via_accumulator;
					if (dec_call_via_accumulator)
						pcl_q <= acc_q;
				end
			endcase
			// Bus writes land last and so win over the core
			if (wr_now && i_wb_sel[0])
			begin
				case (i_wb_adr)
					REG_CTRL: ext_q <= i_wb_dat[CTRL_EXT_BIT];
					REG_ACC: acc_q <= i_wb_dat[7:0];
					REG_BANK: bank_q <= i_wb_dat[3:0];
					REG_STATUS:
					begin
						n_q <= i_wb_dat[STAT_N_BIT];
						z_q <= i_wb_dat[STAT_Z_BIT];
					end
					default: ;
				endcase
			end
			if (wr_now)
			begin
				case (i_wb_adr)
					REG_PTR0: ptr_q[0] <= merge12(ptr_q[0], i_wb_dat, i_wb_sel);
					REG_PTR1: ptr_q[1] <= merge12(ptr_q[1], i_wb_dat, i_wb_sel);
					REG_PTR2: ptr_q[2] <= merge12(ptr_q[2], i_wb_dat, i_wb_sel);
					default: ;
				endcase
			end
		end
	end
	// ****************************************
	// Outputs
	// ****************************************
	assign o_wb_dat = wb_dat_q;
	assign o_wb_ack = ack_q;
	assign o_phase = phase_q;
	assign o_flush = flush_q;
	assign o_mem = mem_q;
	assign o_call = call_q;
	assign o_ret = ret_q;
	assign o_pcl = pcl_q;
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wire at_wr = phase_q == PH_WRITE;
	sequence seq_idle_cycle;
		o_flush[*4];
	endsequence
	sequence seq_live_cycle;
		!o_flush[*4];
	endsequence
	chk_skip_flush: assert property (at_wr && skip_now |=> seq_idle_cycle)
		else $error("zero test did not flush next cycle");
	chk_no_skip: assert property (at_wr && dec_tst && rd_q != 8'h00 |=> seq_live_cycle)
		else $error("nonzero test flushed a cycle");
	chk_skip_two: assert property (at_wr && state_q == ST_SKIP && flush_two_q |=> seq_idle_cycle)
		else $error("two-word skip not flushed twice");
	chk_xor_literal_into_acc_acc: assert property (at_wr && dec_xor_literal_into_acc && !wr_now |=> acc_q == ($past(acc_q) ^ $past(ir_q[7:0])))
		else $error("literal xor wrong");
	chk_xor_acc_with_reg_dest: assert property (at_wr && dec_xor_acc_with_reg |=> o_mem.we == $past(ir_q[BIT_D]))
		else $error("xor destination wrong");
	chk_tst_flags: assert property (at_wr && dec_tst && !wr_now |=> $stable(n_q) && $stable(z_q))
		else $error("test changed flags");
	chk_ext_off: assert property (at_wr && !ext_q && !wr_now |=> $stable(ptr_q[2]) && !o_call)
		else $error("extension acted while off");
	chk_ulnk_ret: assert property (at_wr && ret_now |=> o_ret && o_flush ##1 (!o_ret && o_flush)[*3])
		else $error("pointer-two return wrong");
	chk_call_via_accumulator_acc: assert property (at_wr && dec_call_via_accumulator |=> o_call && o_pcl == $past(acc_q) ##0 seq_idle_cycle)
		else $error("accumulator call wrong");
	chk_push_literal_ptr: assert property (at_wr && dec_push && !wr_now
		|=> o_mem.we && o_mem.wdat == $past(ir_q[7:0]) && ptr_q[2] == 12'($past(ptr_q[2]) - 12'h001))
		else $error("push literal wrong");
	chk_move_two: assert property (at_wr && dec_movs |=> (state_q == ST_MOV2)[*4])
		else $error("indexed move lost second cycle");
	chk_flush_quiet: assert property (at_wr && o_flush |=> !o_mem.we)
		else $error("flushed cycle wrote memory");
endmodule

// file: verif/data_mem_model.sv
// Behavioural data memory that stands on the far side of the decoder
`timescale 1ns/1ps
module data_mem_model import insn_decode_pkg::*; (
	// Clock
	input wire logic i_clk,
	// Request from the core
	input wire mem_req_t i_mem,
	// Read data
	output logic [7:0] o_rdat
);
	// ****************************************
	// Storage
	// ****************************************
	// Full 4096-byte data space
	logic [7:0] mem [0:4095];
	// Fill of a5 XOR the low address byte, zero only where that byte is a5
	initial
	begin
		for (int i = 0; i < 4096; i++)
			mem[i] = 8'ha5 ^ i[7:0];
	end
	// Reads answer at once from the presented address
	assign o_rdat = mem[i_mem.addr];
	// Writes land on the strobe clock only
	always @(posedge i_clk)
	begin
		if (i_mem.we === 1'b1)
			mem[i_mem.addr] <= i_mem.wdat;
	end
endmodule

// file: verif/byte_xor_skip_and_ext_insn_decode_tb_top.sv
// Self-checking bench for the skip, exclusive-OR and extended decoder
`timescale 1ns/1ps
module byte_xor_skip_and_ext_insn_decode_tb_top;
	import insn_decode_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_wb_cyc = 1'b0;
	logic i_wb_stb = 1'b0;
	logic i_wb_we = 1'b0;
	logic [WB_AW-1:0] i_wb_adr = '0;
	logic [3:0] i_wb_sel = 4'hf;
	logic [31:0] i_wb_dat = '0;
	logic [31:0] o_wb_dat;
	logic o_wb_ack;
	logic [15:0] i_insn = 16'h0000;
	logic [1:0] o_phase;
	logic o_flush;
	logic [7:0] i_mem_rdat;
	mem_req_t o_mem;
	logic o_call;
	logic o_ret;
	logic [7:0] o_pcl;
	int error_cnt = 0;
	int samples_checked = 0;
	int flush_n = 0;
	int ret_n = 0;
	int call_n = 0;
	mem_req_t exp_q [$];
	logic [31:0] seed = 32'h4a72;
	logic [31:0] rd;
	logic [7:0] k;
	// Clock at 50 ns
	always #25 i_clk = ~i_clk;
	ext_insn_decoder i_ext_insn_decoder (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
		.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
		.o_wb_ack(o_wb_ack), .i_insn(i_insn), .o_phase(o_phase), .o_flush(o_flush), .i_mem_rdat(i_mem_rdat),
		.o_mem(o_mem), .o_call(o_call), .o_ret(o_ret), .o_pcl(o_pcl));
	data_mem_model i_data_mem_model (.i_clk(i_clk), .i_mem(o_mem), .o_rdat(i_mem_rdat));
	// ****************************************
	// Helpers
	// ****************************************
	// Verdict and end of run
	task automatic test_done();
		$display("compared %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic fail(input string m);
		error_cnt++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	// Value comparison
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp)
			fail(m);
	endtask
	// Pseudo-random byte
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	// One classic Wishbone cycle
	task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge i_clk);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_sel <= 4'hf;
		i_wb_adr <= adr;
		i_wb_dat <= dat;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (o_wb_ack !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			fail("bus timeout");
			test_done();
		end
		rd = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		@(posedge i_clk);
	endtask
	// Read a register and compare
	task automatic rchk(input logic [4:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, '0);
		cmp_val(rd, exp, "register read");
	endtask
	// Present one program word for the next cycle
	task automatic step(input logic [15:0] w);
		int n;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (o_phase !== 2'h3 && n < 8);
		if (n >= 8)
		begin
			fail("phase stuck");
			test_done();
		end
		i_insn <= w;
	endtask
	// Note an expected data memory write
	task automatic expw(input logic [11:0] a, input logic [7:0] d);
		exp_q.push_back(mem_req_t'{a, 1'b1, d});
	endtask
	// Run words, then count flushed cycles, returns and calls
	task automatic run(input logic [15:0] w [$], input int fl, input int rt, input int cl);
		int f0;
		int r0;
		int c0;
		f0 = flush_n;
		r0 = ret_n;
		c0 = call_n;
		foreach (w[i])
			step(w[i]);
		repeat (3) step(16'h0000);
		cmp_val(flush_n - f0, fl * 4, "flushed clocks");
		cmp_val(ret_n - r0, rt, "return pulses");
		cmp_val(call_n - c0, cl, "call pulses");
		cmp_val(exp_q.size(), 0, "missing memory write");
	endtask
	// ****************************************
	// Output monitor
	// ****************************************
	always @(negedge i_clk)
	begin
		if (!i_rst)
		begin
			flush_n += (o_flush === 1'b1);
			ret_n += (o_ret === 1'b1);
			call_n += (o_call === 1'b1);
			if (o_mem.we === 1'b1)
			begin
				if (exp_q.size() == 0)
					fail("unexpected memory write");
				else
					cmp_val(o_mem, exp_q.pop_front(), "memory write");
			end
		end
	end
	// Watchdog
	initial
	begin
		#4000000;
		fail("timeout");
		test_done();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		rchk(REG_CTRL, 32'h0);
		rchk(REG_ACC, 32'h0);
		rchk(REG_PTR2, 32'h0);
		rchk(5'h03, 32'h0);
		$display("reset test done");
		k = rnd();
		wb(1'b1, REG_ACC, 32'hb5);
		run('{16'h0a00 | k}, 0, 0, 0);
		rchk(REG_ACC, {24'h0, 8'hb5 ^ k});
		wb(1'b1, REG_BANK, 32'h2);
		rchk(REG_BANK, 32'h2);
		i_data_mem_model.mem[12'h210] = 8'haf;
		expw(12'h210, 8'hb5 ^ k ^ 8'haf);
		run('{16'h1b10}, 0, 0, 0);
		i_data_mem_model.mem[12'hf85] = 8'hb5 ^ k;
		run('{16'h1885}, 0, 0, 0);
		rchk(REG_ACC, 32'h0);
		rchk(REG_STATUS, 32'h4);
		$display("xor test done");
		i_data_mem_model.mem[12'h210] = 8'h00;
		run('{16'h6710, 16'h1b10}, 1, 0, 0);
		run('{16'h6710, 16'hef00, 16'hf000}, 2, 0, 0);
		i_data_mem_model.mem[12'h210] = 8'h01;
		run('{16'h6710}, 0, 0, 0);
		rchk(REG_STATUS, 32'h4);
		$display("skip test done");
		wb(1'b1, REG_PTR2, 32'h1ec);
		run('{16'hea08, 16'he8e3}, 0, 0, 0);
		rchk(REG_PTR2, 32'h1ec);
		i_data_mem_model.mem[12'h005] = 8'h3c;
		expw(12'h005, 8'h3c);
		run('{16'h1a05}, 0, 0, 0);
		wb(1'b1, REG_CTRL, 32'h1);
		i_data_mem_model.mem[12'h1f1] = 8'h66;
		i_data_mem_model.mem[12'h24b] = 8'h11;
		i_data_mem_model.mem[12'h060] = 8'h22;
		expw(12'h1f1, 8'h66);
		expw(12'h24b, 8'h11);
		expw(12'h060, 8'h22);
		run('{16'h1a05, 16'h1a5f, 16'h1a60}, 0, 0, 0);
		k = rnd();
		expw(12'h1ec, k);
		run('{16'hea00 | k}, 0, 0, 0);
		rchk(REG_PTR2, 32'h1eb);
		$display("extension enable test done");
		for (int f = 0; f < 3; f++)
		begin
			wb(1'b1, REG_PTR0 + 5'(4 * f), 32'h3ff);
			run('{16'he823 | 16'(f << 6)}, 0, 0, 0);
			rchk(REG_PTR0 + 5'(4 * f), 32'h422);
			run('{16'he923 | 16'(f << 6)}, 0, 0, 0);
			rchk(REG_PTR0 + 5'(4 * f), 32'h3ff);
		end
		run('{16'he8e3}, 1, 1, 0);
		rchk(REG_PTR2, 32'h422);
		run('{16'he9e3}, 1, 1, 0);
		rchk(REG_PTR2, 32'h3ff);
		wb(1'b1, REG_ACC, 32'h5a);
		run('{16'h0014}, 1, 0, 1);
		cmp_val(o_pcl, 32'h5a, "call target");
		$display("pointer and call test done");
		wb(1'b1, REG_PTR2, 32'h80);
		i_data_mem_model.mem[12'h085] = 8'h33;
		expw(12'h123, 8'h33);
		expw(12'h086, 8'h33);
		run('{16'heb05, 16'hf123, 16'heb85, 16'hf006}, 0, 0, 0);
		run('{16'heb05, 16'h0123}, 0, 0, 0);
		// Zero test ahead of an indexed move drops both of its words
		i_data_mem_model.mem[12'h210] = 8'h00;
		run('{16'h6710, 16'heb05, 16'hf123}, 2, 0, 0);
		$display("indexed move test done");
		test_done();
	end
endmodule
